// *** fmcsp_buf2.sv ***
/*
 * Two-entry buffer with valid and ready on both sides.
 * Assumes both ends on pclk.
 */
`timescale 1ns/1ps
`default_nettype none
module fmcsp_buf2 #(
   parameter int W     = 32,
   parameter int DEPTH = 2
) (
   // Clock and reset
   input wire logic    pclk,
   input wire logic    presetn,
   // Streams
   fmcsp_stream_if.snk s,
   fmcsp_stream_if.src m
);
   localparam int AW = $clog2(DEPTH);
   logic [W-1:0] mem_r [DEPTH];
   logic [AW-1:0] wp_r;
   logic [AW-1:0] rp_r;
   logic [AW:0]   cnt_r;
   logic          push;
   logic          pop;

   // Handshakes; full and empty from the count
   assign s.ready = (cnt_r != (AW+1)'(DEPTH));
   assign m.valid = (cnt_r != '0);
   assign m.data  = mem_r[rp_r];
   assign push    = s.valid & s.ready;
   assign pop     = m.valid & m.ready;

   // Storage
   always_ff @(posedge pclk) begin
      if (push) begin
         mem_r[wp_r] <= s.data;
      end
   end

   // Pointers and count
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wp_r  <= '0;
         rp_r  <= '0;
         cnt_r <= '0;
      end else begin
         if (push) wp_r <= (wp_r == AW'(DEPTH-1)) ? '0 : wp_r + 1'b1;
         if (pop)  rp_r <= (rp_r == AW'(DEPTH-1)) ? '0 : rp_r + 1'b1;
         cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule // fmcsp_buf2
`default_nettype wire

// *** fmcsp_master.sv ***
/*
 * Fieldbus master cyclic exchange core with CPU stop-error policy,
 * APB register file and master settings.
 * Assumes APB master on pclk; host stop error and switch 1 are pins
 * from another domain; link stream and slave error on pclk.
 */
`timescale 1ns/1ps
`default_nettype none
module fmcsp_master import fmcsp_pkg::*; #(
   parameter int POLL_CYC = POLL_UNIT_CYC
) (
   // Clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   // Host pins
   input  wire logic        cpu_stop_err,
   input  wire logic [15:0] sw1_cfg,
   // Link side
   output logic             tx_valid,
   input  wire logic        tx_ready,
   output logic [31:0]      tx_data,
   input  wire logic        rx_valid,
   output logic             rx_ready,
   input  wire logic [31:0] rx_data,
   input  wire logic        slave_err,
   output logic             clear_req,
   // Settings to the link layer
   output logic [3:0]       baud_sel,
   output logic [6:0]       station_addr,
   output logic [15:0]      data_ctrl_time
);
   // ***********************************************
   // Declarations
   // ***********************************************
   fmcsp_state_e st_r, st_nxt;
   fmcsp_stream_if #(.W(32)) txq_in ();
   fmcsp_stream_if #(.W(32)) txq_out ();
   logic        stop_s1_r, stop_s2_r;
   logic [15:0] sw_s1_r, sw_s2_r;
   logic [2:0]  boot_r;
   logic        boot_done_r, policy_stop_r;
   logic        start_r, modechg_r, modechg_d_r, erract_r;
   logic [7:0]  mode_r;
   logic [3:0]  baud_r;
   logic [6:0]  addr_r;
   logic [15:0] ivl_r, dct_r, wdt_r;
   logic [4:0]  name_r;
   logic [31:0] out_img_r, in_img_r, prdata_r;
   logic        clear_r, pend_r, tick, push;
   logic        wr, rd_setup, mapped, mode_edge;

   // ***********************************************
   // APB decode
   // ***********************************************
   assign wr        = psel & penable & pwrite;
   assign rd_setup  = psel & ~penable;
   assign mapped    = (paddr <= A_IN) && (paddr[1:0] == 2'b00);
   assign pready    = 1'b1;                 // No wait states
   assign pslverr   = psel & penable & ~mapped;
   assign prdata    = prdata_r;
   assign mode_edge = modechg_r & ~modechg_d_r;

   // Read data captured in the setup cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_r <= '0;
      end else if (rd_setup) begin
         case (paddr)
            A_CTRL:  prdata_r <= {29'h0, erract_r, modechg_r, start_r};
            A_STAT:  prdata_r <= {26'h0, clear_r, policy_stop_r,
                                  st_r == ST_HALT, stop_s2_r,
                                  boot_done_r, st_r == ST_RUN};
            A_MODE:  prdata_r <= {24'h0, mode_r};
            A_BAUD:  prdata_r <= {28'h0, baud_r};
            A_ADDR:  prdata_r <= {25'h0, addr_r};
            A_IVL:   prdata_r <= {16'h0, ivl_r};
            A_DCT:   prdata_r <= {16'h0, dct_r};
            A_WDT:   prdata_r <= {16'h0, wdt_r};
            A_NAME:  prdata_r <= {27'h0, name_r};
            A_OUT:   prdata_r <= out_img_r;
            A_IN:    prdata_r <= in_img_r;
            default: prdata_r <= '0;
         endcase
      end
   end

   // ***********************************************
   // Host pin synchronisers and start-up strap
   // ***********************************************
   // Two-flop synchronisers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         stop_s1_r <= 1'b0;
         stop_s2_r <= 1'b0;
         sw_s1_r   <= '0;
         sw_s2_r   <= '0;
      end else begin
         stop_s1_r <= cpu_stop_err;
         stop_s2_r <= stop_s1_r;
         sw_s1_r   <= sw1_cfg;
         sw_s2_r   <= sw_s1_r;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         boot_r        <= '0;
         boot_done_r   <= 1'b0;
         policy_stop_r <= 1'b0;
      end else if (!boot_done_r) begin
         boot_r <= boot_r + 3'h1;
         if (boot_r == 3'(BOOT_CYC - 1)) begin
            boot_done_r   <= 1'b1;
            policy_stop_r <= (sw_s2_r == SW1_STOP);
         end
      end
   end

   // ***********************************************
   // Control and settings registers
   // ***********************************************
   // Request bits and mode word
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         start_r     <= 1'b0;
         modechg_r   <= 1'b0;
         modechg_d_r <= 1'b0;
         erract_r    <= 1'b0;
         mode_r      <= MODE_DEF;
      end else begin
         modechg_d_r <= modechg_r;
         if (wr && paddr == A_CTRL) begin
            start_r   <= pwdata[B_START];
            modechg_r <= pwdata[B_MODECHG];
            erract_r  <= pwdata[B_ERRACT];
         end
         if (wr && paddr == A_MODE) mode_r <= pwdata[7:0];
      end
   end

   // Settings; out-of-range writes are ignored
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         baud_r <= BAUD_DEF;
         addr_r <= ADDR_DEF;
         ivl_r  <= IVL_DEF;
         dct_r  <= DCT_DEF;
         wdt_r  <= WDT_DEF;
         name_r <= '0;
      end else if (wr) begin
         if (paddr == A_BAUD && pwdata <= 32'(BAUD_MAX))
            baud_r <= pwdata[3:0];
         if (paddr == A_ADDR && pwdata <= 32'(ADDR_MAX))
            addr_r <= pwdata[6:0];
         if (paddr == A_IVL && pwdata[31:16] == '0 && pwdata[15:0] != '0)
            ivl_r <= pwdata[15:0];
         if (paddr == A_DCT && pwdata[31:16] == '0 &&
             {3'h0, pwdata[15:0]} >= 19'(wdt_r) * 19'(DCT_FACTOR))
            dct_r <= pwdata[15:0];
         if (paddr == A_WDT && pwdata[31:16] == '0 &&
             pwdata[15:0] != '0 && pwdata[15:0] <= WDT_MAX &&
             19'(pwdata[15:0]) * 19'(DCT_FACTOR) <= {3'h0, dct_r})
            wdt_r <= pwdata[15:0];
         if (paddr == A_NAME && pwdata <= 32'(NAME_MAX))
            name_r <= pwdata[4:0];
      end
   end

   assign baud_sel       = baud_r;
   assign station_addr   = addr_r;
   assign data_ctrl_time = dct_r;

   // ***********************************************
   // Exchange state machine
   // ***********************************************
   // Next state
   always_comb begin
      st_nxt = st_r;
      case (st_r)
         ST_IDLE: begin
            // start request
            // Held mode request keeps exchange off
            if (boot_done_r && start_r && !modechg_r &&
                !(policy_stop_r && stop_s2_r))
               st_nxt = ST_RUN;
         end
         ST_RUN: begin
            if (policy_stop_r && stop_s2_r)
               st_nxt = ST_HALT;
            else if (erract_r && slave_err)
               st_nxt = ST_CLEAR;
            else if (!start_r || mode_edge)
               st_nxt = ST_IDLE;
         end
         ST_HALT, ST_CLEAR: begin
            if (!start_r)
               st_nxt = ST_IDLE;
         end
         default: st_nxt = ST_IDLE;
      endcase
   end

   // State register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) st_r <= ST_IDLE;
      else          st_r <= st_nxt;
   end

   // Clear pulse and clear status
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         clear_r   <= 1'b0;
         clear_req <= 1'b0;
      end else begin
         clear_req <= (st_r == ST_RUN) && (st_nxt == ST_CLEAR);
         clear_r   <= (st_nxt == ST_CLEAR);
      end
   end

   // ***********************************************
   // I/O images
   // ***********************************************
   // output image frozen during stop error
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         out_img_r <= '0;
      else if (wr && paddr == A_OUT && !stop_s2_r)
         out_img_r <= pwdata;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         in_img_r <= '0;
      else if (rx_valid && st_r == ST_RUN)
         in_img_r <= rx_data;
   end
   assign rx_ready = 1'b1;

   // ***********************************************
   // Cyclic transmit
   // ***********************************************
   fmcsp_ticker #(.UNIT_CYC(POLL_CYC)) u_tick (
      .pclk     (pclk),
      .presetn  (presetn),
      .en       (st_r == ST_RUN),
      .interval (ivl_r),
      .tick     (tick)
   );

   assign push          = pend_r & (st_r == ST_RUN);
   assign txq_in.valid  = push;
   assign txq_in.data   = out_img_r;

   // Pending cycle held until the buffer takes it
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         pend_r <= 1'b0;
      else if (st_r != ST_RUN)
         pend_r <= 1'b0;
      else if (tick)
         pend_r <= 1'b1;
      else if (push && txq_in.ready)
         pend_r <= 1'b0;
   end

   fmcsp_buf2 #(.W(32), .DEPTH(2)) u_txq (
      .pclk    (pclk),
      .presetn (presetn),
      .s       (txq_in.snk),
      .m       (txq_out.src)
   );
   assign tx_valid      = txq_out.valid;
   assign tx_data       = txq_out.data;
   assign txq_out.ready = tx_ready;

   // ***********************************************
   // Assertions
   // ***********************************************
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   a_cont_no_halt: assert property (
      st_r == ST_RUN && !policy_stop_r && stop_s2_r |=> st_r != ST_HALT)
      else $error("continue policy halted");
   a_out_frozen: assert property (
      stop_s2_r && $past(stop_s2_r) |-> $stable(out_img_r))
      else $error("output image changed during stop");
   a_in_update: assert property (
      rx_valid && st_r == ST_RUN |=> in_img_r == $past(rx_data))
      else $error("input image not updated");
   a_stop_halts: assert property (
      st_r == ST_RUN && policy_stop_r && stop_s2_r |=> st_r == ST_HALT)
      else $error("stop policy did not halt");
   a_halt_no_tx: assert property (
      st_r == ST_HALT |-> !txq_in.valid)
      else $error("output pushed while halted");
   a_halt_in_held: assert property (
      st_r == ST_HALT [*2] |-> $stable(in_img_r))
      else $error("input image changed while halted");
   a_setting_range: assert property (
      baud_r <= BAUD_MAX && addr_r <= ADDR_MAX && name_r <= NAME_MAX)
      else $error("setting out of range");
   a_ivl_dct: assert property (
      ivl_r != '0 && {3'h0, dct_r} >= 19'(wdt_r) * 19'(DCT_FACTOR))
      else $error("interval or control time invalid");
   a_clear_sent: assert property (
      st_r == ST_RUN && erract_r && slave_err && !(policy_stop_r &&
      stop_s2_r) |=> clear_req ##1 !clear_req)
      else $error("clear request not one pulse");
   a_idle_in_held: assert property (
      st_r != ST_RUN |=> $stable(in_img_r))
      else $error("input image changed while inactive");
   a_policy_held: assert property (
      boot_done_r |=> $stable(policy_stop_r) && boot_done_r)
      else $error("policy changed after start-up");

   c_run: cover property (st_r == ST_IDLE ##1 st_r == ST_RUN);
   c_halt: cover property (st_r == ST_RUN ##1 st_r == ST_HALT);
   c_clear: cover property (clear_req);
   c_stall: cover property (tx_valid && !tx_ready && !txq_in.ready);
endmodule // fmcsp_master
`default_nettype wire

// *** fmcsp_master_tb.sv ***
/*
 * Self-checking bench of the fieldbus master stop-policy block.
 * Assumes the slave model on the link side and zero-wait APB.
 */
`timescale 1ns/1ps
`default_nettype none
module fmcsp_master_tb import fmcsp_pkg::*; ;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic        cpu_stop_err, slave_err, clear_req, stall, rx_en;
   logic        tx_valid, tx_ready, rx_valid, rx_ready;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, tx_data, rx_data, rx_last, tx_last, e;
   logic [15:0] sw1_cfg, data_ctrl_time, tx_cnt, c;
   logic [3:0]  baud_sel;
   logic [6:0]  station_addr;
   int          miscompares, check_count, cyc, clr_cnt;

   fmcsp_master #(.POLL_CYC(4)) fmcsp_master_inst (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .cpu_stop_err(cpu_stop_err),
      .sw1_cfg(sw1_cfg), .tx_valid(tx_valid), .tx_ready(tx_ready),
      .tx_data(tx_data), .rx_valid(rx_valid), .rx_ready(rx_ready),
      .rx_data(rx_data), .slave_err(slave_err), .clear_req(clear_req),
      .baud_sel(baud_sel), .station_addr(station_addr),
      .data_ctrl_time(data_ctrl_time));
   fmcsp_slave_model fmcsp_slave_model_inst (
      .pclk(pclk), .presetn(presetn), .stall(stall), .rx_en(rx_en),
      .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data),
      .rx_valid(rx_valid), .rx_data(rx_data), .rx_last(rx_last),
      .tx_last(tx_last), .tx_cnt(tx_cnt));

   // Clock
   always #4 pclk = ~pclk;
   // Cycle count, hang guard and clear pulse count
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (clear_req === 1'b1) clr_cnt <= clr_cnt + 1;
      if (cyc == 20000) begin
         miscompares = miscompares + 1;
         end_of_test();
      end
   end
   // ****************************
   // Tasks
   // ****************************
   task automatic end_of_test();
      $display("checks=%0d miscompares=%0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      check_count = check_count + 1;
      if (seen !== exp) begin
         miscompares = miscompares + 1;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // One APB transfer, held until pready at a rising edge
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] r,
                      output logic err);
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      r = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic        err;
      apb(1'b1, a, d, r, err);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] m,
                     input logic [31:0] exp);
      logic [31:0] r;
      logic        err;
      apb(1'b0, a, 32'h00000000, r, err);
      chk(r & m, exp);
      chk({31'h00000000, err}, {31'h00000000, a > A_IN});
   endtask
   task automatic do_reset(input logic [15:0] sw);
      presetn      <= 1'b0;
      sw1_cfg      <= sw;
      cpu_stop_err <= 1'b0;
      rx_en        <= 1'b0;
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      repeat (6) @(posedge pclk);
   endtask
   // ****************************
   // Tests
   // ****************************
   initial begin
      pclk = 1'b0;
      {psel, penable, pwrite, slave_err, stall} = 5'h00;
      paddr = 8'h00;
      pwdata = 32'h00000000;
      do_reset(16'h0000);
      rd(A_STAT, 32'h13, 32'h02);
      rd(A_BAUD, 32'hF, 32'h6);
      rd(A_ADDR, 32'h7F, 32'h0);
      rd(A_IVL, 32'hFFFF, 32'h14);
      rd(A_DCT, 32'hFFFF, 32'h64);
      wr(A_BAUD, 32'h9);
      wr(A_BAUD, 32'hA);
      rd(A_BAUD, 32'hF, 32'h9);
      chk({28'h0000000, baud_sel}, 32'h9);
      wr(A_ADDR, 32'h7D);
      wr(A_ADDR, 32'h7E);
      chk({25'h0000000, station_addr}, 32'h7D);
      wr(A_NAME, 32'h11);
      wr(A_NAME, 32'h12);
      rd(A_NAME, 32'h1F, 32'h11);
      wr(A_IVL, 32'h0);
      rd(A_IVL, 32'hFFFF, 32'h14);
      wr(A_DCT, 32'h1D);
      wr(A_DCT, 32'h1E);
      @(posedge pclk);
      chk({16'h0000, data_ctrl_time}, 32'h1E);
      rd(8'h2C, 32'hFFFFFFFF, 32'h0);
      wr(A_IVL, 32'h1);
      wr(A_OUT, 32'hA5A55A5A);
      rx_en <= 1'b1;
      wr(A_CTRL, 32'h1);
      repeat (20) @(posedge pclk);
      rd(A_STAT, 32'h1, 32'h1);
      wr(A_MODE, 32'h2);
      wr(A_CTRL, 32'h3);
      rd(A_MODE, 32'hFF, 32'h2);
      rd(A_STAT, 32'h1, 32'h0);
      wr(A_CTRL, 32'h0);
      wr(A_CTRL, 32'h1);
      stall <= 1'b1;
      repeat (30) @(posedge pclk);
      chk({31'h00000000, tx_valid}, 32'h1);
      c = tx_cnt;
      stall <= 1'b0;
      repeat (3) @(posedge pclk);
      chk({16'h0000, tx_cnt - c}, 32'h2);
      cpu_stop_err <= 1'b1;
      repeat (10) @(posedge pclk);
      wr(A_OUT, 32'h12345678);
      c = tx_cnt;
      repeat (40) @(posedge pclk);
      rd(A_STAT, 32'h1F, 32'h07);
      chk({31'h00000000, tx_cnt > c}, 32'h1);
      chk(tx_last, 32'hA5A55A5A);
      chk({31'h00000000, rx_ready}, 32'h1);
      rx_en <= 1'b0;
      repeat (12) @(posedge pclk);
      rd(A_IN, 32'hFFFFFFFF, rx_last);
      cpu_stop_err <= 1'b0;
      wr(A_CTRL, 32'h5);
      e = rx_last;
      slave_err <= 1'b1;
      @(posedge pclk);
      slave_err <= 1'b0;
      rx_en <= 1'b1;
      repeat (30) @(posedge pclk);
      chk(32'(clr_cnt), 32'h1);
      rd(A_STAT, 32'h21, 32'h20);
      rd(A_IN, 32'hFFFFFFFF, e);
      wr(A_CTRL, 32'h4);
      wr(A_CTRL, 32'h5);
      rd(A_STAT, 32'h1, 32'h1);
      do_reset(16'h0001);
      sw1_cfg <= 16'h0000;
      wr(A_IVL, 32'h1);
      wr(A_OUT, 32'hC3C33C3C);
      wr(A_CTRL, 32'h1);
      rx_en <= 1'b1;
      repeat (20) @(posedge pclk);
      rx_en <= 1'b0;
      repeat (12) @(posedge pclk);
      e = rx_last;
      cpu_stop_err <= 1'b1;
      repeat (12) @(posedge pclk);
      c = tx_cnt;
      rx_en <= 1'b1;
      repeat (40) @(posedge pclk);
      rd(A_STAT, 32'h19, 32'h18);
      chk({16'h0000, tx_cnt}, {16'h0000, c});
      rd(A_IN, 32'hFFFFFFFF, e);
      end_of_test();
   end
endmodule // fmcsp_master_tb
`default_nettype wire

// *** fmcsp_pkg.sv ***
/*
 * Constants of the fieldbus master stop-policy block: register map,
 * field positions, reset values, setting ranges and the FSM states.
 * Assumes a 125 MHz pclk.
 */
`default_nettype none
package fmcsp_pkg;
   // ***********************************************
   // Clock and time units
   // ***********************************************
   localparam int  CLK_MHZ        = 125;
   localparam int  POLL_UNIT_US   = 100;
   localparam int  POLL_UNIT_CYC  = POLL_UNIT_US * CLK_MHZ;
   localparam int  BOOT_CYC       = 4;
   // ***********************************************
   // Register byte addresses
   // ***********************************************
   localparam logic [7:0] A_CTRL = 8'h00;
   localparam logic [7:0] A_STAT = 8'h04;
   localparam logic [7:0] A_MODE = 8'h08;
   localparam logic [7:0] A_BAUD = 8'h0C;
   localparam logic [7:0] A_ADDR = 8'h10;
   localparam logic [7:0] A_IVL  = 8'h14;
   localparam logic [7:0] A_DCT  = 8'h18;
   localparam logic [7:0] A_WDT  = 8'h1C;
   localparam logic [7:0] A_NAME = 8'h20;
   localparam logic [7:0] A_OUT  = 8'h24;
   localparam logic [7:0] A_IN   = 8'h28;
   // ***********************************************
   // Field positions
   // ***********************************************
   localparam int  B_START   = 0;
   localparam int  B_MODECHG = 1;
   localparam int  B_ERRACT  = 2;
   // ***********************************************
   // Ranges and reset values
   // ***********************************************
   localparam logic [15:0] SW1_STOP   = 16'h0001;
   localparam logic [3:0]  BAUD_MAX   = 4'h9;
   localparam logic [3:0]  BAUD_DEF   = 4'h6;
   localparam logic [6:0]  ADDR_MAX   = 7'h7D;
   localparam logic [6:0]  ADDR_DEF   = 7'h00;
   localparam logic [4:0]  NAME_MAX   = 5'h11;
   localparam logic [15:0] IVL_DEF    = 16'h0014;
   localparam logic [15:0] DCT_DEF    = 16'h0064;
   localparam logic [15:0] WDT_DEF    = 16'h0005;
   localparam logic [15:0] WDT_MAX    = 16'hFE01;
   localparam logic [2:0]  DCT_FACTOR = 3'h6;
   localparam logic [7:0]  MODE_DEF   = 8'h00;
   // ***********************************************
   // Exchange states
   // ***********************************************
   typedef enum logic [3:0] {
      ST_IDLE  = 4'b0001,
      ST_RUN   = 4'b0010,
      ST_HALT  = 4'b0100,
      ST_CLEAR = 4'b1000
   } fmcsp_state_e;
endpackage
`default_nettype wire

// *** fmcsp_slave_model.sv ***
/*
 * Slave station model: takes output words, sends input words.
 * Assumes pclk shared with the master and control from the bench.
 */
`timescale 1ns/1ps
`default_nettype none
module fmcsp_slave_model (
   // Clock, reset and test controls
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        stall,
   input  wire logic        rx_en,
   // Link
   input  wire logic        tx_valid,
   output logic             tx_ready,
   input  wire logic [31:0] tx_data,
   output logic             rx_valid,
   output logic [31:0]      rx_data,
   // Observation
   output logic [31:0]      rx_last,
   output logic [31:0]      tx_last,
   output logic [15:0]      tx_cnt
);
   logic [2:0] gap_r;
   // Receiver takes no output words while stalled
   assign tx_ready = !stall;
   // Count and keep taken output words
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_cnt  <= 16'h0000;
         tx_last <= 32'h00000000;
      end else if (tx_valid && tx_ready) begin
         tx_cnt  <= tx_cnt + 16'h0001;
         tx_last <= tx_data;
      end
   end
   // One input word each eight cycles; idle data toggles
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         gap_r    <= 3'h0;
         rx_valid <= 1'b0;
         rx_data  <= 32'h00000000;
         rx_last  <= 32'h00000000;
      end else begin
         gap_r    <= gap_r + 3'h1;
         rx_valid <= rx_en && (gap_r == 3'h7);
         if (rx_en && (gap_r == 3'h7)) begin
            rx_data <= rx_last + 32'h00000101;
            rx_last <= rx_last + 32'h00000101;
         end else begin
            rx_data <= ~rx_data;
         end
      end
   end
endmodule // fmcsp_slave_model
`default_nettype wire

// *** fmcsp_stream_if.sv ***
/*
 * Valid/ready word stream between the block's own modules.
 * Assumes one clock shared by both ends.
 */
`timescale 1ns/1ps
`default_nettype none
interface fmcsp_stream_if #(parameter int W = 32);
   logic         valid;
   logic         ready;
   logic [W-1:0] data;
   modport src (output valid, output data, input ready);
   modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

// *** fmcsp_ticker.sv ***
/*
 * Poll interval ticker: one pulse per interval of UNIT_CYC-cycle units.
 * Assumes interval is never zero while enabled.
 */
`timescale 1ns/1ps
`default_nettype none
module fmcsp_ticker #(
   parameter int UNIT_CYC = 12500
) (
   // Clock and reset
   input wire logic        pclk,
   input wire logic        presetn,
   // Control
   input wire logic        en,
   input wire logic [15:0] interval,
   output logic            tick
);
   logic [31:0] ucnt_r;
   logic [15:0] icnt_r;
   logic        unit_end;

   assign unit_end = (ucnt_r == 32'(UNIT_CYC - 1));
   assign tick     = en & unit_end & (icnt_r >= interval - 16'h0001);

   // Unit and interval counters, cleared while disabled
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ucnt_r <= '0;
         icnt_r <= '0;
      end else if (!en || tick) begin
         ucnt_r <= '0;
         icnt_r <= '0;
      end else if (unit_end) begin
         ucnt_r <= '0;
         icnt_r <= icnt_r + 16'h0001;
      end else begin
         ucnt_r <= ucnt_r + 32'h0000_0001;
      end
   end
endmodule // fmcsp_ticker
`default_nettype wire
